// file: rtl/bcdsc_counter.sv
`timescale 1ns/100ps
// Three-digit decimal event counter with latches and multiplexed output.
module bcdsc_counter #(
  parameter int SCAN_DIV = bcdsc_pkg::SCAN_DIV_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bcdsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the pulse source and the outside party.
  input wire logic count_clk,
  input wire logic count_disable,
  input wire logic latch_hold,
  input wire logic master_clear,
  input wire logic ext_scan_clk,
  // Display side.
  output logic [bcdsc_pkg::BCD_W-1:0] bcd_out,
  output logic [bcdsc_pkg::DIGITS-1:0] digit_sel_n,
  output logic overflow
);

  localparam int N = bcdsc_pkg::DIGITS;
  localparam int W = bcdsc_pkg::BCD_W;
  localparam int P = bcdsc_pkg::PIN_N;

  bcdsc_pkg::bcdsc_pins_t pins_raw, pins_f;
  logic [P-1:0] s1_q, s2_q, s3_q, filt_q;
  logic clk_prev_q, clk_prev_d;
  logic cnt_edge, clear_eff, hold_eff, dis_eff, scan_tick;

  assign pins_raw.count_clk = count_clk;
  assign pins_raw.count_disable = count_disable;
  assign pins_raw.latch_hold = latch_hold;
  assign pins_raw.master_clear = master_clear;
  assign pins_f = filt_q;

  // Each pin passes three flops; a change is accepted only when the
  // second and third agree, which also rejects one-cycle glitches.
  for (genvar p = 0; p < P; p++) begin : g_sync
    logic s1_d, s2_d, s3_d, filt_d;
    always_comb begin
      s1_d = pins_raw[p];
      s2_d = s1_q[p];
      s3_d = s2_q[p];
      filt_d = (s2_q[p] == s3_q[p]) ? s3_q[p] : filt_q[p];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[p] <= 1'b0;
        s2_q[p] <= 1'b0;
        s3_q[p] <= 1'b0;
        filt_q[p] <= 1'b0;
      end else begin
        s1_q[p] <= s1_d;
        s2_q[p] <= s2_d;
        s3_q[p] <= s3_d;
        filt_q[p] <= filt_d;
      end
    end
  end

  // Software control register.
  bcdsc_pkg::bcdsc_ctrl_t ctrl_q, ctrl_d;

  // Effective controls: pin or software bit.
  always_comb begin
    clear_eff = pins_f.master_clear | ctrl_q.sw_clear;
    hold_eff = pins_f.latch_hold | ctrl_q.sw_hold;
    dis_eff = pins_f.count_disable | ctrl_q.sw_disable;
    clk_prev_d = pins_f.count_clk;
    cnt_edge = clk_prev_q & ~pins_f.count_clk & ~dis_eff & ~clear_eff;
  end

  // Decade stages with a synchronous carry chain, so every stage that
  // rolls does so on the same pclk edge.
  logic [W-1:0] dig_q [N];
  logic [W-1:0] dig_d [N];
  wire logic [N:0] carry;
  assign carry[0] = cnt_edge;

  for (genvar i = 0; i < N; i++) begin : g_stage
    // The carry is a net, so each stage drives only its own carry bit.
    assign carry[i+1] = carry[i] & (dig_q[i] == bcdsc_pkg::BCD_NINE);
    always_comb begin
      dig_d[i] = dig_q[i];
      if (clear_eff) begin
        dig_d[i] = bcdsc_pkg::BCD_ZERO;
      end else if (carry[i]) begin
        if (dig_q[i] == bcdsc_pkg::BCD_NINE) begin
          dig_d[i] = bcdsc_pkg::BCD_ZERO;
        end else begin
          dig_d[i] = dig_q[i] + W'(1);
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dig_q[i] <= bcdsc_pkg::BCD_ZERO;
      end else begin
        dig_q[i] <= dig_d[i];
      end
    end
  end

  // Holding latches: transparent while hold is low, frozen while high.
  // Clear does not touch them, so a count survives a held clear.
  logic [W-1:0] held_q [N];
  logic [W-1:0] held_d [N];
  logic [W-1:0] view [N];

  for (genvar i = 0; i < N; i++) begin : g_latch
    always_comb begin
      held_d[i] = hold_eff ? held_q[i] : dig_q[i];
      view[i] = hold_eff ? held_q[i] : dig_q[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        held_q[i] <= bcdsc_pkg::BCD_ZERO;
      end else begin
        held_q[i] <= held_d[i];
      end
    end
  end

  // Overflow pulse, raised on the same edge that rolls the count from 999 to 000.
  logic ovf_q, ovf_d;
  always_comb begin
    ovf_d = carry[N];
  end

  // Scan tick source, stopped while clearing.
  bcdsc_scan_osc #(
    .DIV_CYCLES(SCAN_DIV)
  ) u_osc (
    .pclk(pclk),
    .presetn(presetn),
    .halt(clear_eff),
    .ext_sel(ctrl_q.scan_ext),
    .ext_scan_clk(ext_scan_clk),
    .scan_tick(scan_tick)
  );

  // Digit selector and multiplexed outputs, all registered so the
  // strobe and its BCD value change on the same edge.
  bcdsc_pkg::bcdsc_digit_t sel_q, sel_d;
  logic [1:0] sel_idx;
  logic [W-1:0] bcd_q, bcd_d;
  logic [N-1:0] strobe_q, strobe_d;

  always_comb begin
    sel_d = sel_q;
    if (clear_eff) begin
      sel_d = bcdsc_pkg::DIG_FIRST;
    end else if (scan_tick) begin
      case (sel_q)
        bcdsc_pkg::DIG_FIRST: sel_d = bcdsc_pkg::DIG_SECOND;
        bcdsc_pkg::DIG_SECOND: sel_d = bcdsc_pkg::DIG_THIRD;
        bcdsc_pkg::DIG_THIRD: sel_d = bcdsc_pkg::DIG_FIRST;
        default: sel_d = bcdsc_pkg::DIG_FIRST;
      endcase
    end
    sel_idx = sel_d;
    bcd_d = view[sel_idx];
    if (clear_eff) begin
      strobe_d = '1;
    end else begin
      strobe_d = ~(N'(1) << sel_idx);
    end
  end

  // APB: read data is fetched in the setup cycle, so the access cycle
  // completes with no wait state.
  logic [31:0] rdata_q, rdata_d;
  logic setup_ph, access_ph, addr_ok;

  always_comb begin
    setup_ph = psel & ~penable;
    access_ph = psel & penable;
    addr_ok = (paddr == bcdsc_pkg::CTRL_OFS) ||
              (paddr == bcdsc_pkg::LIVE_OFS) ||
              (paddr == bcdsc_pkg::HELD_OFS) ||
              (paddr == bcdsc_pkg::STATUS_OFS);
    ctrl_d = ctrl_q;
    if (access_ph && pwrite && paddr == bcdsc_pkg::CTRL_OFS) begin
      ctrl_d = bcdsc_pkg::bcdsc_ctrl_t'(pwdata[bcdsc_pkg::CTRL_W-1:0]);
    end
    rdata_d = rdata_q;
    if (setup_ph) begin
      rdata_d = '0;
      case (paddr)
        bcdsc_pkg::CTRL_OFS:
          rdata_d[bcdsc_pkg::CTRL_W-1:0] = ctrl_q;
        bcdsc_pkg::LIVE_OFS:
          rdata_d[bcdsc_pkg::COUNT_W-1:0] = {dig_q[2], dig_q[1], dig_q[0]};
        bcdsc_pkg::HELD_OFS:
          rdata_d[bcdsc_pkg::COUNT_W-1:0] = {view[2], view[1], view[0]};
        bcdsc_pkg::STATUS_OFS:
          rdata_d[bcdsc_pkg::STAT_W-1:0] = {clear_eff, dis_eff, hold_eff,
                                            sel_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // Registers of the selector, outputs and bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= bcdsc_pkg::DIG_FIRST;
      bcd_q <= bcdsc_pkg::BCD_ZERO;
      strobe_q <= '1;
      ovf_q <= 1'b0;
      clk_prev_q <= 1'b0;
      ctrl_q <= bcdsc_pkg::CTRL_RESET;
      rdata_q <= '0;
    end else begin
      sel_q <= sel_d;
      bcd_q <= bcd_d;
      strobe_q <= strobe_d;
      ovf_q <= ovf_d;
      clk_prev_q <= clk_prev_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign bcd_out = bcd_q;
  assign digit_sel_n = strobe_q;
  assign overflow = ovf_q;
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_ok;

  // Checks on the counting, latching and scanning behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [bcdsc_pkg::COUNT_W-1:0] live_vec, held_vec;
  assign live_vec = {dig_q[2], dig_q[1], dig_q[0]};
  assign held_vec = {held_q[2], held_q[1], held_q[0]};

  sequence s_step;
    scan_tick && !clear_eff;
  endsequence

  sequence s_rollover;
    cnt_edge && live_vec == {N{bcdsc_pkg::BCD_NINE}};
  endsequence

  a_stage_range: assert property (dig_q[0] <= bcdsc_pkg::BCD_NINE &&
    dig_q[1] <= bcdsc_pkg::BCD_NINE && dig_q[2] <= bcdsc_pkg::BCD_NINE)
    else $error("stage above nine");
  a_clear_zero: assert property (clear_eff |=> live_vec == '0)
    else $error("clear left a nonzero count");
  a_clear_first: assert property (clear_eff |=>
    sel_q == bcdsc_pkg::DIG_FIRST)
    else $error("selector off first digit in clear");
  a_clear_dark: assert property (clear_eff |=> digit_sel_n == '1)
    else $error("strobe active during clear");
  a_clear_still: assert property (clear_eff [*2] |-> !scan_tick)
    else $error("scan stepped during clear");
  a_disable_keep: assert property (dis_eff |=> $stable(live_vec) ||
    live_vec == '0) else $error("count moved while disabled");
  a_hold_keep: assert property (hold_eff |=>
    held_vec == $past(held_vec)) else $error("latch changed while held");
  a_pass_live: assert property (!hold_eff |=>
    held_vec == $past(live_vec)) else $error("latch not transparent");
  a_ovf_pulse: assert property (s_rollover |=> overflow &&
    live_vec == '0 ##1 !overflow) else $error("bad overflow pulse");
  a_ovf_cause: assert property (overflow |-> $past(cnt_edge))
    else $error("overflow without a count edge");
  a_scan_step: assert property (s_step |=> sel_q != $past(sel_q))
    else $error("selector did not step");
  a_one_strobe: assert property ($countones(~digit_sel_n) <= 1)
    else $error("more than one digit selected");
  a_bcd_match: assert property (!clear_eff |=>
    bcd_out == $past(view[sel_d])) else $error("shown digit mismatch");

  // Strobe and selector are registered from the same next value, so
  // outside clear the strobe must name exactly the selected digit.
  // The reset term skips the first edge, where both still hold reset.
  a_strobe_sel: assert property ($past(presetn) && !$past(clear_eff) |->
    digit_sel_n == ~(N'(1) << sel_q))
    else $error("strobe does not match selector");

  // Away from a units rollover only the units stage may move, so a carry
  // that leaks early into tens is caught here.
  a_units_step: assert property (cnt_edge &&
    dig_q[0] != bcdsc_pkg::BCD_NINE |=> dig_q[0] == $past(dig_q[0]) + W'(1)
    && $stable(dig_q[1])) else $error("units stage stepped wrongly");

  // The cascade pulse must come from a full count rolling over, never
  // from an ordinary edge, or a chained counter would run ahead.
  a_ovf_full: assert property (overflow |->
    $past(live_vec) == {N{bcdsc_pkg::BCD_NINE}})
    else $error("overflow without a full count");

  // After the third digit the selector must return to the first one,
  // never stall or fall into the unused selector code.
  a_sel_wrap: assert property (scan_tick && !clear_eff &&
    sel_q == bcdsc_pkg::DIG_THIRD |=> sel_q == bcdsc_pkg::DIG_FIRST)
    else $error("selector did not wrap to first");

endmodule : bcdsc_counter

// file: rtl/bcdsc_pkg.sv
package bcdsc_pkg;

  localparam int DIGITS = 3;
  localparam int BCD_W = 4;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [3:0] BCD_NINE = 4'h9;

  // Clock and scan timing; the scan period is a slow multiplex rate.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCAN_PERIOD_NS = 1000000;
  localparam int SCAN_DIV_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;

  // APB register map, byte addresses.
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIVE_OFS = 8'h04;
  localparam logic [7:0] HELD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_W = 4;
  localparam int COUNT_W = DIGITS * BCD_W;
  localparam int STAT_W = 5;

  // Software control word, bit 0 is sw_disable.
  typedef struct packed {
    logic scan_ext;
    logic sw_clear;
    logic sw_hold;
    logic sw_disable;
  } bcdsc_ctrl_t;

  // Pin inputs that cross into the pclk domain.
  typedef struct packed {
    logic master_clear;
    logic latch_hold;
    logic count_disable;
    logic count_clk;
  } bcdsc_pins_t;

  localparam int PIN_N = 4;

  // Digit selector states.
  typedef enum logic [1:0] {
    DIG_FIRST,
    DIG_SECOND,
    DIG_THIRD
  } bcdsc_digit_t;

endpackage : bcdsc_pkg

// file: rtl/bcdsc_scan_osc.sv
`timescale 1ns/100ps
// Scan tick source: internal divider or synchronised external scan clock.
module bcdsc_scan_osc #(
  parameter int DIV_CYCLES = bcdsc_pkg::SCAN_DIV_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic halt,
  input wire logic ext_sel,
  input wire logic ext_scan_clk,
  // One-cycle step request.
  output logic scan_tick
);

  localparam int CW = $clog2(DIV_CYCLES + 1);
  localparam logic [CW-1:0] DIV_LAST = CW'(DIV_CYCLES - 1);

  logic [CW-1:0] div_q, div_d;
  logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic lvl_q, lvl_d;
  logic tick_q, tick_d;

  // Next state: the divider is held at zero while halted so the first
  // scan step after clear comes a full period later.
  always_comb begin
    s1_d = ext_scan_clk;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    div_d = div_q;
    tick_d = 1'b0;
    if (halt) begin
      div_d = '0;
    end else if (ext_sel) begin
      div_d = '0;
      tick_d = lvl_d & ~lvl_q;
    end else if (div_q == DIV_LAST) begin
      div_d = '0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + CW'(1);
    end
  end

  // Registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
      tick_q <= tick_d;
    end
  end

  assign scan_tick = tick_q;

  a_halt_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    halt |=> !scan_tick) else $error("scan tick while halted");

endmodule : bcdsc_scan_osc

// file: verif/bcdsc_partner.sv
`timescale 1ns/100ps
// Pulse source and display capture facing the counter's pins.
module bcdsc_partner (
  // Clock.
  input wire logic pclk,
  // Pulse request.
  input wire logic start,
  input wire logic [10:0] num,
  output logic busy,
  output logic count_clk,
  // Display side.
  input wire logic [2:0] digit_sel_n,
  input wire logic [3:0] bcd_out,
  output logic [11:0] shown
);
  logic [10:0] left_q;
  logic [2:0] ph_q;

  initial begin
    busy = 1'b0;
    count_clk = 1'b1;
    shown = 12'h000;
  end

  // Each pulse is four cycles low, four high, so the filter sees it.
  always @(posedge pclk) begin
    if (start && !busy) begin
      left_q <= num;
      ph_q <= 3'h0;
      busy <= 1'b1;
    end else if (busy) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h3) count_clk <= 1'b0;
      if (ph_q == 3'h7) begin
        count_clk <= 1'b1;
        left_q <= left_q - 11'h1;
        if (left_q == 11'h1) busy <= 1'b0;
      end
    end
  end

  // A digit is taken only while its own strobe is low.
  always @(posedge pclk) begin
    for (int k = 0; k < 3; k++) begin
      if (digit_sel_n[k] === 1'b0) shown[k*4 +: 4] <= bcd_out;
    end
  end
endmodule : bcdsc_partner

// file: verif/three_digit_bcd_scan_counter_bench.sv
`timescale 1ns/100ps
module three_digit_bcd_scan_counter_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic count_clk, count_disable, latch_hold, master_clear, ext_scan_clk;
  logic [3:0] bcd_out;
  logic [2:0] digit_sel_n;
  logic overflow, pstart, pbusy, e;
  logic [10:0] pnum;
  logic [11:0] shown;
  int fail_count = 0;
  int num_checks = 0;
  int ovf_n = 0;
  int bad, o0;

  // Free-running bench clock.
  always #5 pclk = ~pclk;

  // Overflow pulses are counted so chained counts can be checked.
  always @(posedge pclk) if (overflow === 1'b1) ovf_n <= ovf_n + 1;

  bcdsc_counter #(.SCAN_DIV(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_clk(count_clk), .count_disable(count_disable),
    .latch_hold(latch_hold), .master_clear(master_clear),
    .ext_scan_clk(ext_scan_clk), .bcd_out(bcd_out),
    .digit_sel_n(digit_sel_n), .overflow(overflow));

  bcdsc_partner part_u (.pclk(pclk), .start(pstart), .num(pnum),
    .busy(pbusy), .count_clk(count_clk), .digit_sel_n(digit_sel_n),
    .bcd_out(bcd_out), .shown(shown));

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++n > 50) begin
        fail_count++;
        final_report;
      end
      @(posedge pclk);
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let one edge pass, so a following call never re-drives psel now.
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(d, exp);
  endtask : rdc

  // Edges are spaced widely; the bound only guards against a stuck source.
  task automatic pulses(input int k);
    int n;
    n = 0;
    pnum <= k[10:0];
    pstart <= 1'b1;
    cyc(1);
    pstart <= 1'b0;
    cyc(2);
    while (pbusy === 1'b1 && n < 20000) begin
      n++;
      cyc(1);
    end
    if (n >= 20000) begin
      fail_count++;
      final_report;
    end
    cyc(8);
  endtask : pulses

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, pstart} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pnum = 11'h000;
    {count_disable, latch_hold, master_clear, ext_scan_clk} = 4'h0;
    cyc(10);
    presetn <= 1'b1;
    cyc(2);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h0);
    pulses(12);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h012);
    cyc(40);
    check(shown, 32'h012);
    count_disable <= 1'b1;
    cyc(6);
    pulses(5);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h012);
    count_disable <= 1'b0;
    latch_hold <= 1'b1;
    cyc(6);
    pulses(3);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h015);
    rdc(bcdsc_pkg::HELD_OFS, 32'h012);
    master_clear <= 1'b1;
    cyc(8);
    bad = 0;
    repeat (30) begin
      @(posedge pclk);
      if (digit_sel_n !== 3'b111) bad++;
    end
    check(bad, 0);
    rdc(bcdsc_pkg::STATUS_OFS, 32'h14);
    pulses(2);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h0);
    rdc(bcdsc_pkg::HELD_OFS, 32'h012);
    master_clear <= 1'b0;
    cyc(6);
    latch_hold <= 1'b0;
    cyc(6);
    rdc(bcdsc_pkg::HELD_OFS, 32'h0);
    o0 = ovf_n;
    pulses(999);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h999);
    check(ovf_n - o0, 0);
    pulses(1);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h0);
    check(ovf_n - o0, 1);
    apb(1'b1, bcdsc_pkg::CTRL_OFS, 32'hC);
    rdc(bcdsc_pkg::STATUS_OFS, 32'h10);
    apb(1'b1, bcdsc_pkg::CTRL_OFS, 32'h8);
    cyc(2);
    for (int k = 1; k < 5; k++) begin
      ext_scan_clk <= 1'b1;
      cyc(4);
      ext_scan_clk <= 1'b0;
      cyc(4);
      apb(1'b0, bcdsc_pkg::STATUS_OFS, 32'h0);
      check(d & 32'h3, k % 3);
    end
    // Software hold and disable bits must act like their pins.
    apb(1'b1, bcdsc_pkg::CTRL_OFS, 32'h2);
    pulses(4);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h004);
    rdc(bcdsc_pkg::HELD_OFS, 32'h000);
    apb(1'b1, bcdsc_pkg::CTRL_OFS, 32'h1);
    pulses(3);
    rdc(bcdsc_pkg::LIVE_OFS, 32'h004);
    rdc(bcdsc_pkg::HELD_OFS, 32'h004);
    rdc(bcdsc_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check(e, 1'b1);
    check(d, 32'h0);
    final_report;
  end
endmodule : three_digit_bcd_scan_counter_bench
